// *** wpu_pkg.sv ***
// shared constants and types for the window pixel unpacker
package wpu_pkg;
    localparam logic [15:0] REG_FMT_OFS   = 16'h0832;
    localparam logic [15:0] REG_STAT_OFS  = 16'h0834;
    localparam logic [15:0] FMT_RESET     = 16'h0000;
    localparam int          MAIN_SEL_LSB  = 0;
    localparam int          OVL_SEL_LSB   = 4;
    localparam logic [15:0] FMT_RW_MASK   = 16'h0077;
    localparam logic [2:0]  CODE_8BPP     = 3'h0;
    localparam logic [2:0]  CODE_16BPP    = 3'h1;
    localparam logic [2:0]  CODE_32BPP    = 3'h2;
    localparam logic [15:0] WORD_STEP     = 16'h0002;
    localparam logic [15:0] ADDR_RESET    = 16'h0000;
    localparam int          STAT_MAIN_ERR = 0;
    localparam int          STAT_OVL_ERR  = 1;
    localparam int          STAT_BUSY     = 4;

    typedef enum logic [1:0] {WPU_D8, WPU_D16, WPU_D32, WPU_DBAD} wpu_depth_t;
    typedef enum logic [1:0] {ST_WORD, ST_ODD, ST_HI} wpu_state_t;
endpackage

// *** wpu_px_if.sv ***
// carrier between the sequencer and the pixel field splitter
`timescale 1ns/1ps
interface wpu_px_if;
    wpu_pkg::wpu_depth_t fmt;
    logic [15:0]         src;
    logic [15:0]         lo;
    logic [7:0]          r;
    logic [7:0]          g;
    logic [7:0]          b;
    modport user   (output fmt, output src, output lo, input r, input g, input b);
    modport unpack (input fmt, input src, input lo, output r, output g, output b);
endinterface

// *** wpu_unpack.sv ***
// splits one memory word (or word pair) into msb-aligned colour components
`timescale 1ns/1ps
module wpu_unpack
(
    wpu_px_if.unpack px
);
    always_comb
    begin
        px.r = 8'h00;
        px.g = 8'h00;
        px.b = 8'h00;
        case (px.fmt)
            wpu_pkg::WPU_D8:
            begin
                // low bits zero filled: cheaper than replication, exact at zero only
                px.r = {px.src[7:5], 5'h00};   // [R5]
                px.g = {px.src[4:2], 5'h00};   // [R5]
                px.b = {px.src[1:0], 6'h00};   // [R5]
            end
            wpu_pkg::WPU_D16:
            begin
                px.r = {px.src[15:11], 3'h0};  // [R6]
                px.g = {px.src[10:5], 2'h0};   // [R6]
                px.b = {px.src[4:0], 3'h0};    // [R6]
            end
            wpu_pkg::WPU_D32:
            begin
                px.r = px.src[7:0];            // [R7]
                px.g = px.lo[15:8];            // [R7]
                px.b = px.lo[7:0];             // [R7]
            end
            default:
            begin
                px.r = 8'h00;
            end
        endcase
    end
endmodule // wpu_unpack

// *** wpu_top.sv ***
// window pixel unpacker: format register, word sequencing and pixel output
// How it works
// [R1] only 8, 16, 32 bpp for both windows
// [R2] main depth from format bits 2..0
// [R3] overlay depth from format bits 6..4
// [R4] 8bpp: two pixels per word, low first
// [R5] 8bpp pixel: red3 top, green3, blue2
// [R6] 16bpp pixel: red5, green6, blue5
// [R7] 32bpp: green/blue word then red word
// [R8] unassigned select codes flagged as error
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module wpu_top
#(
    parameter logic [2:0] CODE_8  = wpu_pkg::CODE_8BPP,
    parameter logic [2:0] CODE_16 = wpu_pkg::CODE_16BPP,
    parameter logic [2:0] CODE_32 = wpu_pkg::CODE_32BPP
)
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        frame_start,
    input  wire logic        word_valid,
    input  wire logic        word_window,
    input  wire logic [15:0] word_data,
    output logic             word_ready,
    output logic      [15:0] word_addr,
    output logic             pix_valid,
    input  wire logic        pix_ready,
    output logic             pix_window,
    output logic      [7:0]  pix_r,
    output logic      [7:0]  pix_g,
    output logic      [7:0]  pix_b
);
    logic [15:0]          fmt_q, fmt_d;
    logic [15:0]          rdata_q, rdata_d;
    wpu_pkg::wpu_state_t  st_q, st_d;
    wpu_pkg::wpu_depth_t  main_depth, ovl_depth, cur_depth;
    logic [15:0]          hold_q, hold_d;
    logic                 win_q, win_d;
    logic [15:0]          addr_q, addr_d;
    logic                 pv_q, pv_d;
    logic                 pw_q, pw_d;
    logic [7:0]           r_q, r_d, g_q, g_d, b_q, b_d;
    logic                 out_free, take;

    wpu_px_if px ();

    wpu_unpack u_unpack
    (
        .px (px.unpack)
    );

    function automatic wpu_pkg::wpu_depth_t decode(input logic [2:0] code);
        if (code == CODE_8)
            decode = wpu_pkg::WPU_D8;
        else if (code == CODE_16)
            decode = wpu_pkg::WPU_D16;
        else if (code == CODE_32)
            decode = wpu_pkg::WPU_D32;
        else
            decode = wpu_pkg::WPU_DBAD;                          // [R8]
    endfunction

    assign main_depth = decode(fmt_q[wpu_pkg::MAIN_SEL_LSB +: 3]); // [R2]
    assign ovl_depth  = decode(fmt_q[wpu_pkg::OVL_SEL_LSB +: 3]);  // [R3]
    assign cur_depth  = word_window ? ovl_depth : main_depth;

    // register port: single-cycle writes, read data one cycle later
    always_comb
    begin
        fmt_d   = fmt_q;
        rdata_d = 16'h0000;
        if (reg_wr && reg_addr == wpu_pkg::REG_FMT_OFS)
            fmt_d = reg_wdata & wpu_pkg::FMT_RW_MASK;
        if (reg_rd && reg_addr == wpu_pkg::REG_FMT_OFS)
            rdata_d = fmt_q;
        else if (reg_rd && reg_addr == wpu_pkg::REG_STAT_OFS)
        begin
            rdata_d[wpu_pkg::STAT_MAIN_ERR] = (main_depth == wpu_pkg::WPU_DBAD); // [R8]
            rdata_d[wpu_pkg::STAT_OVL_ERR]  = (ovl_depth == wpu_pkg::WPU_DBAD);  // [R8]
            rdata_d[wpu_pkg::STAT_BUSY]     = (st_q != wpu_pkg::ST_WORD);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fmt_q   <= wpu_pkg::FMT_RESET;
            rdata_q <= 16'h0000;
        end
        else
        begin
            fmt_q   <= fmt_d;
            rdata_q <= rdata_d;
        end
    end

    assign out_free = !pv_q || pix_ready;

    // a 32bpp first half needs no output slot, so it is taken even while stalled
    always_comb
    begin
        case (st_q)
            wpu_pkg::ST_WORD:
                word_ready = (cur_depth == wpu_pkg::WPU_D32) ? 1'b1 : out_free;
            wpu_pkg::ST_HI:
                word_ready = out_free;
            default:
                word_ready = 1'b0;                               // [R4]
        endcase
    end

    assign take = word_valid && word_ready;

    always_comb
    begin
        st_d    = st_q;
        hold_d  = hold_q;
        win_d   = win_q;
        addr_d  = addr_q;
        pv_d    = pv_q && !pix_ready;
        pw_d    = pw_q;
        r_d     = r_q;
        g_d     = g_q;
        b_d     = b_q;
        px.fmt  = wpu_pkg::WPU_DBAD;
        px.src  = word_data;
        px.lo   = hold_q;
        if (take)
            addr_d = addr_q + wpu_pkg::WORD_STEP;                // [R4] [R7]
        if (frame_start)
            addr_d = wpu_pkg::ADDR_RESET;
        case (st_q)
            wpu_pkg::ST_WORD:
            begin
                px.fmt = cur_depth;
                if (take)
                begin
                    win_d = word_window;
                    case (cur_depth)                             // [R1]
                        wpu_pkg::WPU_D8:
                        begin
                            pv_d   = 1'b1;
                            hold_d = {8'h00, word_data[15:8]};   // [R4]
                            st_d   = wpu_pkg::ST_ODD;
                        end
                        wpu_pkg::WPU_D16:
                            pv_d = 1'b1;
                        wpu_pkg::WPU_D32:
                        begin
                            hold_d = word_data;                  // [R7]
                            st_d   = wpu_pkg::ST_HI;
                        end
                        default:
                            pv_d = pv_q && !pix_ready;           // [R8] word dropped
                    endcase
                    if (cur_depth == wpu_pkg::WPU_D8 || cur_depth == wpu_pkg::WPU_D16)
                    begin
                        pw_d = word_window;
                        r_d  = px.r;
                        g_d  = px.g;
                        b_d  = px.b;
                    end
                end
            end
            wpu_pkg::ST_ODD:
            begin
                px.fmt = wpu_pkg::WPU_D8;
                px.src = hold_q;
                if (out_free)
                begin
                    pv_d = 1'b1;                                 // [R4]
                    pw_d = win_q;
                    r_d  = px.r;
                    g_d  = px.g;
                    b_d  = px.b;
                    st_d = wpu_pkg::ST_WORD;
                end
            end
            wpu_pkg::ST_HI:
            begin
                px.fmt = wpu_pkg::WPU_D32;
                if (take)
                begin
                    pv_d = 1'b1;                                 // [R7]
                    pw_d = win_q;
                    r_d  = px.r;
                    g_d  = px.g;
                    b_d  = px.b;
                    st_d = wpu_pkg::ST_WORD;
                end
            end
            default:
                st_d = wpu_pkg::ST_WORD;
        endcase
        // a new frame drops any half-assembled pixel
        if (frame_start)
            st_d = wpu_pkg::ST_WORD;
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q   <= wpu_pkg::ST_WORD;
            hold_q <= 16'h0000;
            win_q  <= 1'b0;
            addr_q <= wpu_pkg::ADDR_RESET;
            pv_q   <= 1'b0;
            pw_q   <= 1'b0;
            r_q    <= 8'h00;
            g_q    <= 8'h00;
            b_q    <= 8'h00;
        end
        else
        begin
            st_q   <= st_d;
            hold_q <= hold_d;
            win_q  <= win_d;
            addr_q <= addr_d;
            pv_q   <= pv_d;
            pw_q   <= pw_d;
            r_q    <= r_d;
            g_q    <= g_d;
            b_q    <= b_d;
        end
    end

    assign reg_rdata  = rdata_q;
    assign word_addr  = addr_q;
    assign pix_valid  = pv_q;
    assign pix_window = pw_q;
    assign pix_r      = r_q;
    assign pix_g      = g_q;
    assign pix_b      = b_q;

    property p_only_three;                                       // [R1]
        @(posedge sys_clk) disable iff (!resetn)
        $rose(pv_q) |-> $past(st_q) != wpu_pkg::ST_WORD || $past(cur_depth) != wpu_pkg::WPU_DBAD;
    endproperty
    a_only_three: assert property (p_only_three) else $error("pixel from bad depth"); // [R1]

    property p_main_sel;                                         // [R2]
        @(posedge sys_clk) disable iff (!resetn)
        (reg_wr && reg_addr == wpu_pkg::REG_FMT_OFS && reg_wdata[2:0] == CODE_16)
            |=> main_depth == wpu_pkg::WPU_D16;
    endproperty
    a_main_sel: assert property (p_main_sel) else $error("main select not applied"); // [R2]

    property p_ovl_sel;                                          // [R3]
        @(posedge sys_clk) disable iff (!resetn)
        (reg_wr && reg_addr == wpu_pkg::REG_FMT_OFS && reg_wdata[6:4] == CODE_32)
            |=> ovl_depth == wpu_pkg::WPU_D32;
    endproperty
    a_ovl_sel: assert property (p_ovl_sel) else $error("overlay select not applied"); // [R3]

    property p_odd_pixel;                                        // [R4]
        @(posedge sys_clk) disable iff (!resetn)
        (take && st_q == wpu_pkg::ST_WORD && cur_depth == wpu_pkg::WPU_D8 && !frame_start)
            |=> !word_ready && pv_q && st_q == wpu_pkg::ST_ODD ##1 pv_q;
    endproperty
    a_odd_pixel: assert property (p_odd_pixel) else $error("odd pixel not pending"); // [R4]

    property p_rgb332;                                           // [R5]
        @(posedge sys_clk) disable iff (!resetn)
        (take && st_q == wpu_pkg::ST_WORD && cur_depth == wpu_pkg::WPU_D8)
            |=> r_q[7:5] == $past(word_data[7:5]) && g_q[7:5] == $past(word_data[4:2])
                && b_q[7:6] == $past(word_data[1:0]);
    endproperty
    a_rgb332: assert property (p_rgb332) else $error("332 fields wrong"); // [R5]

    property p_rgb565;                                           // [R6]
        @(posedge sys_clk) disable iff (!resetn)
        (take && st_q == wpu_pkg::ST_WORD && cur_depth == wpu_pkg::WPU_D16)
            |=> r_q[7:3] == $past(word_data[15:11]) && g_q[7:2] == $past(word_data[10:5]);
    endproperty
    a_rgb565: assert property (p_rgb565) else $error("565 fields wrong"); // [R6]

    property p_red_word;                                         // [R7]
        @(posedge sys_clk) disable iff (!resetn)
        (take && st_q == wpu_pkg::ST_HI && !frame_start)
            |=> pv_q && r_q == $past(word_data[7:0]) && st_q == wpu_pkg::ST_WORD;
    endproperty
    a_red_word: assert property (p_red_word) else $error("32bpp red wrong"); // [R7]

    property p_bad_code;                                         // [R8]
        @(posedge sys_clk) disable iff (!resetn)
        (reg_rd && reg_addr == wpu_pkg::REG_STAT_OFS && main_depth == wpu_pkg::WPU_DBAD)
            |=> reg_rdata[wpu_pkg::STAT_MAIN_ERR];
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("bad code not flagged"); // [R8]
endmodule // wpu_top

// *** wpu_mem_model.sv ***
// behavioural display memory controller offering 16-bit words
`timescale 1ns/1ps
module wpu_mem_model
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        go,
    input  wire logic        slow,
    input  wire logic        win,
    input  wire logic [15:0] lim,
    input  wire logic [15:0] word_addr,
    input  wire logic        word_ready,
    output logic             word_valid,
    output logic             word_window,
    output logic      [15:0] word_data
);
    logic [15:0] mem [0:15];
    logic [15:0] cur;
    logic        gap_q;
    // byte addresses step by two per word, so bit 0 is dropped
    assign cur         = mem[word_addr[4:1]];
    assign word_valid  = go && (word_addr < lim) && !gap_q;
    // released bus shows the inverse so a stale word never passes for data
    assign word_data   = word_valid ? cur : ~cur;
    assign word_window = win;
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            gap_q <= 1'b0;
        else
            gap_q <= slow && word_valid && word_ready;
    end
endmodule // wpu_mem_model

// *** tb.sv ***
// self-checking bench for the window pixel unpacker
`timescale 1ns/1ps
module tb;
    logic        sys_clk;
    logic        resetn;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        frame_start;
    logic        word_valid;
    logic        word_window;
    logic [15:0] word_data;
    logic        word_ready;
    logic [15:0] word_addr;
    logic        pix_valid;
    logic        pix_ready;
    logic        pix_window;
    logic [7:0]  pix_r;
    logic [7:0]  pix_g;
    logic [7:0]  pix_b;
    logic        go;
    logic        slow;
    logic        win;
    logic        stall;
    logic [15:0] lim;
    logic [2:0]  codes [0:2];
    logic [24:0] got_q [$];
    int          err_total;
    int          tests_run;
    int          cycles;

    wpu_top uut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .frame_start(frame_start), .word_valid(word_valid), .word_window(word_window),
        .word_data(word_data), .word_ready(word_ready), .word_addr(word_addr),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_window(pix_window),
        .pix_r(pix_r), .pix_g(pix_g), .pix_b(pix_b));
    wpu_mem_model mc (.sys_clk(sys_clk), .resetn(resetn), .go(go), .slow(slow),
        .win(win), .lim(lim), .word_addr(word_addr), .word_ready(word_ready),
        .word_valid(word_valid), .word_window(word_window), .word_data(word_data));

    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    // sink stalls every other cycle when asked, to hold pixels back
    always @(posedge sys_clk)
        pix_ready <= stall ? ~pix_ready : 1'b1;

    always @(posedge sys_clk)
        if (pix_valid === 1'b1 && pix_ready === 1'b1)
            got_q.push_back({pix_window, pix_r, pix_g, pix_b});

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
        @(posedge sys_clk);
    endtask

    function automatic logic [24:0] px_exp(input int d, input int k, input logic w);
        logic [15:0] a;
        logic [15:0] b;
        logic [7:0]  p;
        a = mc.mem[(d == 2) ? 2 * k : ((d == 1) ? k : k / 2)];
        b = mc.mem[(2 * k + 1) % 16];
        p = k[0] ? a[15:8] : a[7:0];
        case (d)
            0: return {w, p[7:5], 5'h00, p[4:2], 5'h00, p[1:0], 6'h00};
            1: return {w, a[15:11], 3'h0, a[10:5], 2'h0, a[4:0], 3'h0};
            default: return {w, b[7:0], a[15:8], a[7:0]};
        endcase
    endfunction

    // sixteen words per frame; depth 3 stands for an unassigned code
    task automatic run(input int d, input logic w, input logic [15:0] fmt);
        int n;
        int i;
        n = (d == 0) ? 32 : ((d == 1) ? 16 : ((d == 2) ? 8 : 0));
        for (i = 0; i < 16; i++)
            mc.mem[i] = 16'(16'h3c5a ^ (i * 16'h1d27) ^ (d * 16'h0f0f));
        wr(wpu_pkg::REG_FMT_OFS, fmt);
        got_q.delete();
        frame_start <= 1'b1;
        win         <= w;
        lim         <= 16'h0020;
        slow        <= (d == 2);
        stall       <= (d == 1);
        @(posedge sys_clk);
        // words are offered only after the new frame has cleared the address
        frame_start <= 1'b0;
        go          <= 1'b1;
        @(posedge sys_clk);
        i = 0;
        while ((got_q.size() < n || word_addr !== 16'h0020) && i < 300)
        begin
            @(posedge sys_clk);
            i++;
        end
        chk("frame finished in time", 32'h00000001, {31'h0, i < 300});
        go    <= 1'b0;
        stall <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("pixel count", n, got_q.size());
        for (i = 0; i < got_q.size(); i++)
            chk("pixel", px_exp(d, i, w), got_q[i]);
        chk("word address", 16'h0020, word_addr);
    endtask

    initial
    begin
        int          d;
        logic [15:0] v;
        codes[0] = wpu_pkg::CODE_8BPP;
        codes[1] = wpu_pkg::CODE_16BPP;
        codes[2] = wpu_pkg::CODE_32BPP;
        resetn = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        frame_start = 1'b0;
        go = 1'b0;
        slow = 1'b0;
        win = 1'b0;
        stall = 1'b0;
        lim = 16'h0000;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        chk("address after reset", wpu_pkg::ADDR_RESET, word_addr);
        chk("pix_valid after reset", 1'b0, pix_valid);
        rd(wpu_pkg::REG_FMT_OFS, v);
        chk("format reset", wpu_pkg::FMT_RESET, v);
        wr(wpu_pkg::REG_FMT_OFS, 16'hffff);
        rd(wpu_pkg::REG_FMT_OFS, v);
        chk("format fields", wpu_pkg::FMT_RW_MASK, v);
        rd(wpu_pkg::REG_STAT_OFS, v);
        chk("bad codes flagged", 2'b11, v[1:0]);
        rd(16'h0830, v);
        chk("unmapped read", 16'h0000, v);
        for (d = 0; d < 3; d++)
        begin
            run(d, 1'b0, {9'h000, codes[(d + 1) % 3], 1'b0, codes[d]});
            run(d, 1'b1, {9'h000, codes[d], 1'b0, 3'h7});
        end
        run(3, 1'b0, 16'h0075);
        end_sim();
    end
endmodule // tb
